// ---- pint_engine.v ----
// Purpose: Pin interrupt and pattern match engine, eight channels.
// Assumes: Pins are already routed by system_config_block; excluded pins never arrive.
// Notes: Pattern mode replaces pin interrupts on the outputs; slices chain into products.
`timescale 1ns/100ps
`include "pint_defines.vh"
module pint_engine #(
  parameter NCH = `PINT_NCH
) (
  input  wire             clk,           // System clock.
  input  wire             sys_rst,       // Asynchronous reset, active high.
  input  wire [NCH-1:0]   pin_in,        // Selected pins from system_config_block.
  input  wire             pmatch_mode,   // 1: pattern match drives outputs.
  input  wire [NCH-1:0]   level_mode,    // Per channel: 1 level, 0 edge.
  input  wire [NCH-1:0]   rise_en,       // Edge: rising enable. Level: enable.
  input  wire [NCH-1:0]   fall_en,       // Edge: falling enable. Level: 1 high-active.
  input  wire [NCH-1:0]   rise_clr,      // Pulse: clear pending rising edge.
  input  wire [NCH-1:0]   fall_clr,      // Pulse: clear pending falling edge.
  input  wire [3*NCH-1:0] slice_src,     // Input index for each slice.
  input  wire [3*NCH-1:0] slice_cond,    // Condition code for each slice.
  input  wire [NCH-1:0]   slice_end,     // Slice ends a product term.
  input  wire             event_en,      // Pulse cpu_event_input on match.
  input  wire             sleep_req,     // Clocks stopping; arms wake logic.
  output reg  [NCH-1:0]   rise_pend,     // Pending rising edges.
  output reg  [NCH-1:0]   fall_pend,     // Pending falling edges.
  output reg  [NCH-1:0]   pin_irq,       // One interrupt line per channel.
  output reg  [NCH-1:0]   pmatch_state,  // Registered product term results.
  output reg              cpu_event_input, // One-cycle match notification.
  output wire             wake_req       // Asynchronous wake request.
);
  wire [NCH-1:0] lvl;
  reg  [NCH-1:0] lvl_d_r;
  reg  [NCH-1:0] evt_pend_r;
  reg  [NCH-1:0] slice_hit;
  reg  [NCH-1:0] term;
  reg            acc;
  reg  [NCH-1:0] irq_nxt;
  reg  [NCH-1:0] pin_arm_r;
  reg  [NCH-1:0] slice_done;
  reg            done;
  integer j;
  integer k;

  pint_sync #(.W(NCH)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pin_in),
    .q       (lvl)
  );

  wire [NCH-1:0] rise_det = lvl & ~lvl_d_r;
  wire [NCH-1:0] fall_det = ~lvl & lvl_d_r;

  function slice_eval;
    input [2:0] cond;
    input       now;
    input       prev;
    input       stk;
    begin
      case (cond)
        `PINT_C_ALWAYS: slice_eval = 1'b1;
        `PINT_C_RISE:   slice_eval = stk | (now & ~prev);
        `PINT_C_FALL:   slice_eval = stk | (~now & prev);
        `PINT_C_EITHER: slice_eval = stk | (now ^ prev);
        `PINT_C_HIGH:   slice_eval = now;
        `PINT_C_LOW:    slice_eval = ~now;
        default:        slice_eval = 1'b0;
      endcase
    end
  endfunction

  // Edge slices are sticky so a transition can meet a later level in one product.
  always @*
  begin
    acc = 1'b1;
    done = 1'b0;
    term = {NCH{1'b0}};
    slice_hit = {NCH{1'b0}};
    slice_done = {NCH{1'b0}};
    for (j = 0; j < NCH; j = j + 1)
    begin
      slice_hit[j] = slice_eval(slice_cond[3*j +: 3], lvl[slice_src[3*j +: 3]],
                                lvl_d_r[slice_src[3*j +: 3]], evt_pend_r[j]);
      acc = acc & slice_hit[j];
      if (slice_end[j])
      begin
        term[j] = acc;
        acc = 1'b1;
      end
    end
    // Every slice learns whether the product it belongs to fires this cycle.
    for (j = NCH - 1; j >= 0; j = j - 1)
    begin
      if (slice_end[j])
        done = term[j];
      slice_done[j] = done;
    end
  end

  always @*
  begin
    if (pmatch_mode)
      irq_nxt = term;
    else
      irq_nxt = (level_mode & rise_en & ~(lvl ^ fall_en))
              | (~level_mode & (rise_pend | fall_pend));
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lvl_d_r         <= {NCH{1'b0}};
      rise_pend       <= {NCH{1'b0}};
      fall_pend       <= {NCH{1'b0}};
      evt_pend_r      <= {NCH{1'b0}};
      pin_irq         <= {NCH{1'b0}};
      pmatch_state    <= {NCH{1'b0}};
      cpu_event_input <= 1'b0;
      pin_arm_r       <= {NCH{1'b0}};
    end
    else
    begin
      lvl_d_r <= lvl;
      // Set wins over a clear in the same cycle.
      rise_pend <= (rise_pend & ~rise_clr) | (rise_det & rise_en & ~level_mode);
      fall_pend <= (fall_pend & ~fall_clr) | (fall_det & fall_en & ~level_mode);
      for (k = 0; k < NCH; k = k + 1)
        if (slice_done[k])
          evt_pend_r[k] <= 1'b0;
        else if (slice_cond[3*k +: 3] == `PINT_C_RISE ||
                 slice_cond[3*k +: 3] == `PINT_C_FALL ||
                 slice_cond[3*k +: 3] == `PINT_C_EITHER)
          evt_pend_r[k] <= slice_hit[k] & pmatch_mode;
        else
          evt_pend_r[k] <= 1'b0;
      pin_irq         <= irq_nxt;
      pmatch_state    <= term;
      cpu_event_input <= pmatch_mode & event_en & |(term & ~pmatch_state);
      pin_arm_r       <= (sleep_req & ~pmatch_mode) ? (rise_en | fall_en) : {NCH{1'b0}};
    end
  end

  // Combinational wake path works with clocks stopped: any armed pin differing from
  // its last sampled level, or a raised pin_irq line, asks for wake.
  // Gated by sleep and pin mode so a stale arm never wakes from pattern mode.
  assign wake_req = sleep_req & ~pmatch_mode
                  & (|(pin_arm_r & (pin_in ^ lvl_d_r)) | (|pin_irq));
endmodule // pint_engine

// ---- pint_defines.vh ----
// Purpose: Constants for the pin interrupt and pattern match engine.
// Assumes: Included by the design files of this block only.
// Notes: Condition codes select the test a pattern slice applies to its input.
`ifndef PINT_DEFINES_VH
`define PINT_DEFINES_VH
`define PINT_NCH        8
`define PINT_CW         3
`define PINT_C_ALWAYS   3'h0
`define PINT_C_RISE     3'h1
`define PINT_C_FALL     3'h2
`define PINT_C_EITHER   3'h3
`define PINT_C_HIGH     3'h4
`define PINT_C_LOW      3'h5
`define PINT_C_NEVER    3'h6
`define PINT_RST_CFG    8'h00
`endif

// ---- pint_sync.v ----
// Purpose: Three-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs come from pins outside the clock domain.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/100ps
module pint_sync #(
  parameter W = 8
) (
  input  wire         clk,     // System clock.
  input  wire         sys_rst, // Asynchronous reset, active high.
  input  wire [W-1:0] d,       // Asynchronous inputs.
  output reg  [W-1:0] q        // Filtered synchronous level.
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q    <= {W{1'b0}};
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1)
        if (s2_r[i] == s3_r[i])
          q[i] <= s3_r[i];
    end
  end
endmodule // pint_sync

// ---- pint_monitor.sv ----
// Purpose: Port checks for pint_engine.
// Assumes: Bound onto the engine by the bench.
// Notes: Channels 0 and 1 stand for the rest.
`timescale 1ns/100ps
module pint_monitor #(
  parameter NCH = 8
) (
  input wire           clk,             // Clock.
  input wire           sys_rst,         // Reset.
  input wire           pmatch_mode,     // Pattern mode.
  input wire [NCH-1:0] level_mode,      // Level select.
  input wire [NCH-1:0] rise_en,         // Enable.
  input wire [NCH-1:0] rise_clr,        // Clear.
  input wire           event_en,        // Event enable.
  input wire           sleep_req,       // Sleep.
  input wire [NCH-1:0] rise_pend,       // Pending.
  input wire [NCH-1:0] fall_pend,       // Pending.
  input wire [NCH-1:0] pin_irq,         // Requests.
  input wire           cpu_event_input, // Event.
  input wire           wake_req         // Wake.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence edge0;
    !pmatch_mode && !level_mode[0];
  endsequence
  a_reset_clear: assert property ($past(sys_rst) |-> pin_irq == 0 && rise_pend == 0)
    else $error("outputs set after reset");
  a_pend_hold: assert property (rise_pend[0] && !rise_clr[0] |=> rise_pend[0])
    else $error("pending lost");
  a_edge_irq: assert property (edge0 ##0 rise_pend[0] && !rise_clr[0] ##1 edge0 |-> pin_irq[0])
    else $error("edge request missing");
  a_irq_cause: assert property (edge0 ##1 edge0 ##0 pin_irq[0] |-> $past(rise_pend[0] | fall_pend[0]))
    else $error("edge request without pending");
  a_level_off: assert property ($past(!pmatch_mode && level_mode[1] && !rise_en[1]) |-> !pin_irq[1])
    else $error("disabled level request");
  a_no_wake: assert property (pmatch_mode || !sleep_req |-> !wake_req)
    else $error("wake from pattern mode");
  a_evt_cause: assert property (cpu_event_input |-> $past(event_en) && $past(pmatch_mode))
    else $error("event without enable");
  a_evt_pulse: assert property (cpu_event_input |=> !cpu_event_input)
    else $error("event longer than a cycle");
endmodule // pint_monitor

// ---- pint_cpu_model.sv ----
// Purpose: Processor side stand-in.
// Assumes: One clock domain.
// Notes: Counting event cycles exposes a held event.
`timescale 1ns/100ps
module pint_cpu_model (
  input  wire       clk,      // Clock.
  input  wire       sys_rst,  // Reset.
  input  wire [7:0] irq,      // Requests.
  input  wire       evt,      // Event.
  output reg  [7:0] seen_r,   // Lines raised.
  output reg  [3:0] evt_cnt_r // Event cycles.
);
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      {seen_r, evt_cnt_r} <= 12'h000;
    else
      {seen_r, evt_cnt_r} <= {seen_r | irq, evt_cnt_r + {3'h0, evt}};
endmodule // pint_cpu_model

// ---- pint_engine_tb.sv ----
// Purpose: Self-checking bench for pint_engine.
// Assumes: Pins change well apart.
// Notes: Eight cycles cover sync, detection and output.
`timescale 1ns/100ps
module pint_engine_tb;
  reg         clk, sys_rst, pmatch_mode, event_en, sleep_req;
  reg  [7:0]  pin_in, level_mode, rise_en, fall_en, rise_clr, fall_clr, slice_end;
  reg  [23:0] slice_src, slice_cond;
  wire [7:0]  rise_pend, fall_pend, pin_irq, pmatch_state, seen_r;
  wire [3:0]  evt_cnt_r;
  wire        cpu_event_input, wake_req;
  integer     num_errors, n_tests;
  pint_engine pint_engine_i (.*);
  pint_cpu_model pint_cpu_model_i (.clk(clk), .sys_rst(sys_rst), .irq(pin_irq),
    .evt(cpu_event_input), .seen_r(seen_r), .evt_cnt_r(evt_cnt_r));
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string name, input [7:0] exp, input [7:0] got);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD %0s expected %h seen %h", name, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #2000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial
  begin
    {num_errors, n_tests} = 64'h0;
    {sys_rst, pmatch_mode, event_en, sleep_req} = 4'h8;
    {pin_in, level_mode, rise_en, fall_en, rise_clr, fall_clr, slice_end} = 56'h0;
    slice_src = 24'h000002;
    slice_cond = 24'hDB6DB4;
    tick(8);
    sys_rst = 1'b0;
    {rise_en, fall_en, pin_in} = 24'h010101;
    tick(8);
    chk("rise_pend", 8'h01, rise_pend);
    chk("fall_pend", 8'h00, fall_pend);
    chk("pin_irq", 8'h01, pin_irq);
    rise_clr = 8'h01;
    tick(1);
    {rise_clr, pin_in} = 16'h0000;
    tick(8);
    chk("fall_pend", 8'h01, fall_pend);
    chk("rise_pend", 8'h00, rise_pend);
    fall_clr = 8'h01;
    tick(1);
    {fall_clr, level_mode, rise_en} = 24'h000202;
    tick(8);
    chk("pin_irq", 8'h02, pin_irq);
    pin_in = 8'h02;
    tick(8);
    chk("pin_irq", 8'h00, pin_irq);
    $display("edge and level tests done");
    {sleep_req, rise_en, pin_in} = 17'h10A0A;
    tick(8);
    chk("wake_req", 8'h01, {7'h00, wake_req});
    {pmatch_mode, event_en, slice_end} = 10'h301;
    tick(8);
    pin_in = 8'h0E;
    tick(8);
    chk("term", 8'h01, pin_irq & slice_end);
    chk("pmatch_state", 8'h01, pmatch_state & slice_end);
    chk("wake_req", 8'h00, {7'h00, wake_req});
    chk("evt_cnt", 8'h01, {4'h0, evt_cnt_r});
    chk("seen", 8'h0B, seen_r);
    $display("wake and pattern tests done");
    wrap_up;
  end
endmodule // pint_engine_tb
bind pint_engine pint_monitor #(.NCH(NCH)) pint_monitor_i (.*);
